//--- rtl/hbp_top.sv
/*
  Control logic of a ten-output half-bridge driver: reset and
  sleep handling, configuration capture from the link domain,
  three PWM channels, free-wheeling and dead-time gate control.
  Assumes rst is the logic-supply power-on reset, en_pin and
  load_supply_fault are raw pins, and cfg_* are stable on the
  link_clk edge where cfg_write is high.
*/
// Overview of operation
// (RULE1) Logic supply power-on reset clears registers, outputs high-Z.
// (RULE2) Load supply dropout gates outputs off but keeps every register.
// (RULE3) Enable high gives normal mode, charge pump on, outputs usable.
// (RULE4) Enable low gives sleep, outputs off, registers back to reset.
// (RULE5) Logic supply low holds the whole block in reset.
// (RULE6) Power-up indication reads 0 after logic supply reset.
// (RULE7) Enable-low reset also shows power-up indication 0 afterwards.
// (RULE8) Bridges drive continuously by activation bits or by PWM.
// (RULE9) Three PWM channels, 8-bit duty each, any bridge assignable.
// (RULE10) Rate code 01 is 80 Hz, 10 is 100 Hz, 11 is 200 Hz.
// (RULE11) Rate code 00 stops the channel; nonzero starts a period.
// (RULE12) Rate and duty changes take effect glitch-free at period end.
// (RULE13) Active or passive free-wheeling selectable, passive after reset.
// (RULE14) Active free-wheel only if both on-times exceed dead-time sum.
// (RULE15) Active high side on stopped channel gives low side instead; code does so only with active free-wheeling, else both off.
// (RULE16) Host sets stop, freewheel, assign, duty, rate, activation.
// (RULE17) Host sets activation before rate for paralleled outputs.
// (RULE18) LED select on outputs 1 and 2 picks low open-load threshold.
// (RULE19) Host LED sequence: stop, assign, duty, activate, LED, rate.
// (RULE20) Assignment 00 means continuous; 01 to 11 pick channel 1-3.
// (RULE21) On-time per period is duty divided by 256.
module hbp_top #(
   parameter logic [hbp_pkg::CNT_W-1:0] PERIOD_80_CYC  =
      hbp_pkg::CNT_W'(hbp_pkg::CLK_HZ / hbp_pkg::RATE_80_HZ),
   parameter logic [hbp_pkg::CNT_W-1:0] PERIOD_100_CYC =
      hbp_pkg::CNT_W'(hbp_pkg::CLK_HZ / hbp_pkg::RATE_100_HZ),
   parameter logic [hbp_pkg::CNT_W-1:0] PERIOD_200_CYC =
      hbp_pkg::CNT_W'(hbp_pkg::CLK_HZ / hbp_pkg::RATE_200_HZ)
) (
   input  wire logic                              mclk,
   input  wire logic                              rst,
   input  wire logic                              en_pin,
   input  wire logic                              load_supply_fault,
   input  wire logic                              link_clk,
   input  wire logic                              cfg_write,
   input  wire logic [hbp_pkg::NUM_BRIDGE-1:0]    cfg_act_upper,
   input  wire logic [hbp_pkg::NUM_BRIDGE-1:0]    cfg_act_lower,
   input  wire logic [2*hbp_pkg::NUM_BRIDGE-1:0]  cfg_assign,
   input  wire logic [3*hbp_pkg::DUTY_W-1:0]      cfg_duty,
   input  wire logic [5:0]                        cfg_rate,
   input  wire logic                              cfg_active_fw,
   input  wire logic                              cfg_led_mode_out1,
   input  wire logic                              cfg_led_mode_out2,
   input  wire logic                              cfg_powerup_ack,
   output logic                                   powerup_seen_flag_low,
   output logic [hbp_pkg::NUM_BRIDGE-1:0]         upper_gate,
   output logic [hbp_pkg::NUM_BRIDGE-1:0]         lower_gate,
   output logic                                   charge_pump_on,
   output logic                                   sleep_mode,
   output logic [1:0]                             led_openload_sel,
   output logic [hbp_pkg::NUM_CHAN-1:0]           pwm_running
);
   localparam int NB = hbp_pkg::NUM_BRIDGE;
   localparam int NC = hbp_pkg::NUM_CHAN;

   // Link domain: configuration shadow, handshake toggle and status synchroniser
   hbp_pkg::hbp_cfg_type link_cfg_reg;
   logic                 link_toggle_reg;
   logic                 flag_meta_reg;
   logic                 flag_sync_reg;

   // Core domain synchronisers
   logic                 tog_meta_reg;
   logic                 tog_sync_reg;
   logic                 tog_seen_reg;
   logic                 en_meta_reg;
   logic                 en_sync_reg;
   logic                 vs_meta_reg;
   logic                 vs_sync_reg;

   // Core domain configuration and status
   hbp_pkg::hbp_cfg_type cfg_reg;
   logic                 powerup_flag_reg;
   logic                 load_cfg;
   logic                 sleep;
   logic                 outputs_off;

   // Channel results
   logic [NC-1:0]        ch_on;
   logic [NC-1:0]        ch_fw;
   logic [NC-1:0]        ch_run;

   // Gate control
   logic [NB-1:0]        want_upper;
   logic [NB-1:0]        want_lower;
   logic [NB-1:0]        upper_next;
   logic [NB-1:0]        lower_next;
   logic [NB-1:0]        upper_reg;
   logic [NB-1:0]        lower_reg;
   logic [hbp_pkg::DEAD_W-1:0] dead_reg [NB];
   logic                 cp_reg;
   logic                 sleep_reg;
   logic [1:0]           led_reg;
   logic [NC-1:0]        run_reg;

   // Capture of one configuration word per host write
   always_ff @(posedge link_clk or posedge rst)
   begin
      if (rst)
      begin
         link_cfg_reg    <= hbp_pkg::CFG_RESET;
         link_toggle_reg <= 1'b0;
      end
      else if (cfg_write)
      begin
         link_cfg_reg.act_upper   <= cfg_act_upper;
         link_cfg_reg.act_lower   <= cfg_act_lower;
         link_cfg_reg.assign_sel  <= cfg_assign;
         link_cfg_reg.duty        <= cfg_duty;
         link_cfg_reg.rate        <= cfg_rate;
         link_cfg_reg.active_fw   <= cfg_active_fw;
         link_cfg_reg.led_mode    <= {cfg_led_mode_out2,
                                      cfg_led_mode_out1};
         link_cfg_reg.powerup_ack <= cfg_powerup_ack;
         link_toggle_reg          <= ~link_toggle_reg;
      end
   end

   // Status back into the link domain
   always_ff @(posedge link_clk or posedge rst)
   begin
      if (rst)
      begin
         flag_meta_reg <= 1'b0;
         flag_sync_reg <= 1'b0;
      end
      else
      begin
         flag_meta_reg <= powerup_flag_reg;
         flag_sync_reg <= flag_meta_reg;
      end
   end

   assign powerup_seen_flag_low = flag_sync_reg;

   // Pins and handshake into the core domain
   always_ff @(posedge mclk or posedge rst)
   begin
      if (rst)
      begin
         en_meta_reg  <= 1'b0;
         en_sync_reg  <= 1'b0;
         vs_meta_reg  <= 1'b0;
         vs_sync_reg  <= 1'b0;
         tog_meta_reg <= 1'b0;
         tog_sync_reg <= 1'b0;
         tog_seen_reg <= 1'b0;
      end
      else
      begin
         en_meta_reg  <= en_pin;
         en_sync_reg  <= en_meta_reg;
         vs_meta_reg  <= load_supply_fault;
         vs_sync_reg  <= vs_meta_reg;
         tog_meta_reg <= link_toggle_reg;
         tog_sync_reg <= tog_meta_reg;
         tog_seen_reg <= tog_sync_reg;
      end
   end

   assign sleep       = ~en_sync_reg;
   assign load_cfg    = tog_sync_reg != tog_seen_reg;
   assign outputs_off = sleep | vs_sync_reg;

   // Configuration registers; a load-supply fault leaves them alone
   always_ff @(posedge mclk or posedge rst)
   begin
      if (rst) // RULE1 RULE5
         cfg_reg <= hbp_pkg::CFG_RESET; // RULE13
      else if (sleep) // RULE4
         cfg_reg <= hbp_pkg::CFG_RESET;
      else if (load_cfg) // RULE2
         cfg_reg <= link_cfg_reg;
   end

   // Power-up indication: cleared by any reset, set by host
   always_ff @(posedge mclk or posedge rst)
   begin
      if (rst) // RULE6
         powerup_flag_reg <= 1'b0;
      else if (sleep) // RULE7
         powerup_flag_reg <= 1'b0;
      else if (load_cfg && link_cfg_reg.powerup_ack)
         powerup_flag_reg <= 1'b1;
   end

   // PWM channels
   genvar g;
   generate
      for (g = 0; g < NC; g++)
      begin : gen_chan
         hbp_chan_if ch_if ();

         assign ch_if.rate = cfg_reg.rate[2*g +: 2];
         assign ch_if.duty =
            cfg_reg.duty[hbp_pkg::DUTY_W*g +: hbp_pkg::DUTY_W]; // RULE9
         assign ch_on[g]   = ch_if.pwm_on;
         assign ch_fw[g]   = ch_if.fw_ok;
         assign ch_run[g]  = ch_if.running;

         hbp_pwm_chan #(
            .P80  (PERIOD_80_CYC),
            .P100 (PERIOD_100_CYC),
            .P200 (PERIOD_200_CYC)
         ) u_chan (
            .mclk  (mclk),
            .rst   (rst),
            .clear (sleep),
            .bus   (ch_if.chan)
         );
      end
   endgenerate

   // Requested switch per bridge from activation and channel
   always_comb
   begin
      logic [1:0] sel;
      logic       up;
      logic       lo;
      logic       on;
      logic       run;
      logic       fwok;
      logic       afw;
      sel  = hbp_pkg::ASSIGN_NONE;
      up   = 1'b0;
      lo   = 1'b0;
      on   = 1'b0;
      run  = 1'b0;
      fwok = 1'b0;
      afw  = cfg_reg.active_fw;
      for (int b = 0; b < NB; b++)
      begin
         sel = cfg_reg.assign_sel[2*b +: 2];
         up  = cfg_reg.act_upper[b];
         lo  = cfg_reg.act_lower[b];
         want_upper[b] = 1'b0;
         want_lower[b] = 1'b0;
         if (sel == hbp_pkg::ASSIGN_NONE) // RULE20
         begin
            // Both bits set would short the bridge: keep it off
            want_upper[b] = up & ~lo; // RULE8
            want_lower[b] = lo & ~up;
         end
         else
         begin
            on   = ch_on[sel - hbp_pkg::ASSIGN_CH1];
            run  = ch_run[sel - hbp_pkg::ASSIGN_CH1];
            fwok = ch_fw[sel - hbp_pkg::ASSIGN_CH1];
            if (up && !lo)
            begin
               if (!run)
                  want_lower[b] = afw; // RULE15
               else if (on)
                  want_upper[b] = 1'b1;
               else
                  want_lower[b] = afw & fwok; // RULE14
            end
            else if (lo && !up)
            begin
               if (run && on)
                  want_lower[b] = 1'b1;
               else if (run)
                  want_upper[b] = afw & fwok; // RULE14
            end
         end
      end
   end

   // Switch turn-on waits for the other side and dead time
   always_comb
   begin
      for (int b = 0; b < NB; b++)
      begin
         upper_next[b] = want_upper[b] &&
            (upper_reg[b] || (!lower_reg[b] &&
             dead_reg[b] == '0));
         lower_next[b] = want_lower[b] &&
            (lower_reg[b] || (!upper_reg[b] &&
             dead_reg[b] == '0));
      end
   end

   always_ff @(posedge mclk or posedge rst)
   begin
      if (rst) // RULE1
      begin
         upper_reg <= '0;
         lower_reg <= '0;
      end
      else if (outputs_off) // RULE2 RULE4
      begin
         upper_reg <= '0;
         lower_reg <= '0;
      end
      else
      begin
         upper_reg <= upper_next;
         lower_reg <= lower_next;
      end
   end

   always_ff @(posedge mclk or posedge rst)
   begin
      if (rst)
      begin
         for (int b = 0; b < NB; b++)
            dead_reg[b] <= '0;
      end
      else
      begin
         for (int b = 0; b < NB; b++)
         begin
            if (upper_reg[b] && (!upper_next[b] || outputs_off))
               dead_reg[b] <= hbp_pkg::DEAD_HL;
            else if (lower_reg[b] &&
                     (!lower_next[b] || outputs_off))
               dead_reg[b] <= hbp_pkg::DEAD_LH;
            else if (dead_reg[b] != '0)
               dead_reg[b] <= dead_reg[b] - 8'h01;
         end
      end
   end

   assign upper_gate = upper_reg;
   assign lower_gate = lower_reg;

   // Mode and status outputs
   always_ff @(posedge mclk or posedge rst)
   begin
      if (rst)
      begin
         cp_reg    <= 1'b0;
         sleep_reg <= 1'b1;
         led_reg   <= '0;
         run_reg   <= '0;
      end
      else
      begin
         cp_reg    <= ~sleep; // RULE3
         sleep_reg <= sleep;
         led_reg   <= cfg_reg.led_mode; // RULE18
         run_reg   <= ch_run;
      end
   end

   assign charge_pump_on   = cp_reg;
   assign sleep_mode       = sleep_reg;
   assign led_openload_sel = led_reg;
   assign pwm_running      = run_reg;
endmodule

//--- inc/hbp_pkg.sv
/*
  Shared constants, configuration layout and arithmetic for the
  half-bridge PWM and mode control block.
  Assumes a 40 MHz core clock.
*/
package hbp_pkg;
   localparam int NUM_BRIDGE = 10;
   localparam int NUM_CHAN   = 3;
   localparam int DUTY_W     = 8;
   localparam int CNT_W      = 20;
   localparam int DEAD_W     = 8;

   localparam longint CLK_HZ       = 40000000;
   localparam longint RATE_80_HZ   = 80;
   localparam longint RATE_100_HZ  = 100;
   localparam longint RATE_200_HZ  = 200;
   localparam int     CLK_PERIOD_NS = 25;

   // Cross-conduction dead times, high-to-low and low-to-high
   localparam int DEAD_HL_NS  = 1000;
   localparam int DEAD_LH_NS  = 1000;
   localparam int DEAD_HL_CYC =
      (DEAD_HL_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam int DEAD_LH_CYC =
      (DEAD_LH_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam logic [DEAD_W-1:0] DEAD_HL = DEAD_W'(DEAD_HL_CYC);
   localparam logic [DEAD_W-1:0] DEAD_LH = DEAD_W'(DEAD_LH_CYC);
   localparam logic [CNT_W-1:0]  DEAD_SUM =
      CNT_W'(DEAD_HL_CYC + DEAD_LH_CYC);

   localparam logic [1:0] RATE_STOP = 2'h0;
   localparam logic [1:0] RATE_80   = 2'h1;
   localparam logic [1:0] RATE_100  = 2'h2;
   localparam logic [1:0] RATE_200  = 2'h3;
   localparam logic [1:0] ASSIGN_NONE = 2'h0;
   localparam logic [1:0] ASSIGN_CH1  = 2'h1;

   typedef struct packed {
      logic [NUM_BRIDGE-1:0]   act_upper;
      logic [NUM_BRIDGE-1:0]   act_lower;
      logic [2*NUM_BRIDGE-1:0] assign_sel;
      logic [3*DUTY_W-1:0]     duty;
      logic [5:0]              rate;
      logic                    active_fw;
      logic [1:0]              led_mode;
      logic                    powerup_ack;
   } hbp_cfg_type;

   localparam hbp_cfg_type CFG_RESET = '0;

   // On-time in cycles: duty / 256 of the period
   function automatic logic [CNT_W-1:0] on_cycles
      (input logic [DUTY_W-1:0] duty,
       input logic [CNT_W-1:0]  period);
      logic [CNT_W+DUTY_W-1:0] prod;
      prod = {{CNT_W{1'b0}}, duty} * {{DUTY_W{1'b0}}, period};
      return prod[DUTY_W +: CNT_W];
   endfunction
endpackage

//--- inc/hbp_chan_if.sv
/*
  Carrier between the top and one PWM channel generator.
  Assumes both ends run on the core clock.
*/
interface hbp_chan_if;
   logic [1:0]                 rate;
   logic [hbp_pkg::DUTY_W-1:0] duty;
   logic                       pwm_on;
   logic                       fw_ok;
   logic                       running;

   modport chan (input rate, input duty,
                 output pwm_on, output fw_ok, output running);
   modport user (output rate, output duty,
                 input pwm_on, input fw_ok, input running);
endinterface

//--- rtl/hbp_pwm_chan.sv
/*
  One PWM channel: period counter, duty compare and shadowed
  rate and duty taken over at period boundaries; rate code 00 or clear stops the channel at once.
  Assumes rate and duty are stable core-clock signals.
*/
module hbp_pwm_chan #(
   parameter logic [hbp_pkg::CNT_W-1:0] P80  = 20'h7a120,
   parameter logic [hbp_pkg::CNT_W-1:0] P100 = 20'h61a80,
   parameter logic [hbp_pkg::CNT_W-1:0] P200 = 20'h30d40
) (
   input  wire logic  mclk,
   input  wire logic  rst,
   input  wire logic  clear,
   hbp_chan_if.chan   bus
);
   logic [1:0]                 rate_reg;
   logic [hbp_pkg::DUTY_W-1:0] duty_reg;
   logic [hbp_pkg::CNT_W-1:0]  period_reg;
   logic [hbp_pkg::CNT_W-1:0]  cnt_reg;
   logic [hbp_pkg::CNT_W-1:0]  on_cyc;
   logic                       on_reg;
   logic                       fw_reg;

   function automatic logic [hbp_pkg::CNT_W-1:0] period_of
      (input logic [1:0] code);
      case (code)
         hbp_pkg::RATE_80:  return P80;
         hbp_pkg::RATE_100: return P100;
         hbp_pkg::RATE_200: return P200;
         default:           return P80;
      endcase
   endfunction

   always_ff @(posedge mclk or posedge rst)
   begin
      if (rst)
      begin
         rate_reg   <= hbp_pkg::RATE_STOP;
         duty_reg   <= '0;
         period_reg <= '0;
         cnt_reg    <= '0;
      end
      else if (clear || bus.rate == hbp_pkg::RATE_STOP) // RULE11
      begin
         rate_reg   <= hbp_pkg::RATE_STOP;
         cnt_reg    <= '0;
      end
      else if (rate_reg == hbp_pkg::RATE_STOP ||
               cnt_reg == period_reg - 20'h00001) // RULE12
      begin
         rate_reg   <= bus.rate; // RULE10
         duty_reg   <= bus.duty;
         period_reg <= period_of(bus.rate);
         cnt_reg    <= '0;
      end
      else
         cnt_reg <= cnt_reg + 20'h00001;
   end

   assign on_cyc = hbp_pkg::on_cycles(duty_reg, period_reg);

   always_ff @(posedge mclk or posedge rst)
   begin
      if (rst)
      begin
         on_reg <= 1'b0;
         fw_reg <= 1'b0;
      end
      else
      begin
         on_reg <= rate_reg != hbp_pkg::RATE_STOP &&
                   cnt_reg < on_cyc; // RULE21
         fw_reg <= on_cyc > hbp_pkg::DEAD_SUM &&
                   period_reg - on_cyc > hbp_pkg::DEAD_SUM; // RULE14
      end
   end

   assign bus.pwm_on  = on_reg;
   assign bus.fw_ok   = fw_reg;
   assign bus.running = rate_reg != hbp_pkg::RATE_STOP;
endmodule

//--- testbench/hbp_top_properties.sv
/*
  Port-level checker for the half-bridge control top.
  Assumes rst is the only reset; watched outputs are mclk flops except powerup_seen_flag_low, a link_clk flop.
*/
module hbp_top_properties (
   input wire logic       mclk,
   input wire logic       rst,
   input wire logic       en_pin,
   input wire logic       load_supply_fault,
   input wire logic       powerup_seen_flag_low,
   input wire logic [9:0] upper_gate,
   input wire logic [9:0] lower_gate,
   input wire logic       charge_pump_on,
   input wire logic       sleep_mode,
   input wire logic [1:0] led_openload_sel,
   input wire logic [2:0] pwm_running
);
   timeunit 1ns;
   timeprecision 1ps;

   logic [7:0] off_cnt_reg;
   logic [7:0] slp_cnt_reg;

   // Cycles since upper switch 0 was last on
   always_ff @(posedge mclk or posedge rst)
      if (rst)
         off_cnt_reg <= 8'hff;
      else if (upper_gate[0])
         off_cnt_reg <= 8'h00;
      else if (off_cnt_reg != 8'hff)
         off_cnt_reg <= off_cnt_reg + 8'h01;

   always_ff @(posedge mclk or posedge rst)
      if (rst || !sleep_mode)
         slp_cnt_reg <= 8'h00;
      else if (slp_cnt_reg != 8'hff)
         slp_cnt_reg <= slp_cnt_reg + 8'h01;

   default clocking cb @(posedge mclk);
   endclocking
   default disable iff (rst);

   sleep_gates_a: assert property (
      sleep_mode && $past(sleep_mode) |-> (upper_gate | lower_gate) == '0)
      else $error("gate on during sleep");
   pump_mode_a: assert property (
      charge_pump_on == !sleep_mode)
      else $error("charge pump disagrees with mode");
   no_overlap_a: assert property (
      (upper_gate & lower_gate) == '0)
      else $error("both switches of a bridge on");
   dead_time_a: assert property (
      $rose(lower_gate[0]) |-> off_cnt_reg >= hbp_pkg::DEAD_HL_CYC - 2)
      else $error("lower switch on inside dead time");
   fault_off_a: assert property (
      load_supply_fault [*4] |-> (upper_gate | lower_gate) == '0)
      else $error("gate on during load supply fault");
   sleep_entry_a: assert property (
      !en_pin [*4] |-> sleep_mode)
      else $error("no sleep with enable low");
   wake_a: assert property (
      en_pin [*4] |-> charge_pump_on && !sleep_mode)
      else $error("no normal mode with enable high");
   sleep_run_a: assert property (
      sleep_mode [*3] |-> pwm_running == '0 && led_openload_sel == '0)
      else $error("config survives sleep");
   flag_clear_a: assert property (
      slp_cnt_reg >= 8'h28 |-> !powerup_seen_flag_low)
      else $error("power-up flag kept in sleep");
endmodule

bind hbp_top hbp_top_properties u_hbp_top_properties (
   .mclk, .rst, .en_pin, .load_supply_fault, .powerup_seen_flag_low,
   .upper_gate, .lower_gate, .charge_pump_on, .sleep_mode,
   .led_openload_sel, .pwm_running);

//--- testbench/hbp_host_model.sv
/*
  Host model: hands whole configuration words over on the link clock.
  Assumes link_clk runs and callers use send only.
*/
module hbp_host_model (
   input  wire logic           link_clk,
   output logic                cfg_write,
   output hbp_pkg::hbp_cfg_type cfg
);
   timeunit 1ns;
   timeprecision 1ps;

   initial
   begin
      cfg_write = 1'b0;
      cfg = hbp_pkg::CFG_RESET;
   end

   task automatic send(input hbp_pkg::hbp_cfg_type c);
      @(posedge link_clk);
      cfg_write <= 1'b1;
      cfg <= c;
      @(posedge link_clk);
      cfg_write <= 1'b0;
      // Fields are not meaningful outside a write
      cfg <= ~c;
      // Keep writes at least two link cycles apart
      repeat (2) @(posedge link_clk);
   endtask
endmodule

//--- testbench/half_bridge_pwm_mode_control_test.sv
/*
  Self-checking bench for the half-bridge control top.
  Assumes the host model and the bound checker are compiled first.
*/
module half_bridge_pwm_mode_control_test;
   timeunit 1ns;
   timeprecision 1ps;

   typedef struct packed {
      logic [9:0]  up;
      logic [9:0]  lo;
      logic [19:0] asg;
      logic        fw;
      logic [1:0]  led;
      logic [9:0]  eu;
      logic [9:0]  el;
   } hbp_row_type;

   localparam int PER [4] = '{0, 1000, 800, 400};
   localparam hbp_row_type ROWS [6] = '{
      '{10'h001, 10'h000, 20'h00000, 1'b0, 2'h1, 10'h001, 10'h000},
      '{10'h000, 10'h002, 20'h00000, 1'b0, 2'h2, 10'h000, 10'h002},
      '{10'h004, 10'h004, 20'h00000, 1'b0, 2'h3, 10'h000, 10'h000},
      '{10'h008, 10'h000, 20'h00040, 1'b1, 2'h0, 10'h000, 10'h008},
      '{10'h008, 10'h000, 20'h00040, 1'b0, 2'h0, 10'h000, 10'h000},
      '{10'h000, 10'h010, 20'h00200, 1'b1, 2'h0, 10'h000, 10'h000}};

   logic                 mclk;
   logic                 rst;
   logic                 en_pin;
   logic                 load_supply_fault;
   logic                 link_clk;
   logic                 cfg_write;
   hbp_pkg::hbp_cfg_type cfg;
   hbp_pkg::hbp_cfg_type c;
   logic                 flag;
   logic                 pump;
   logic                 slp;
   logic [9:0]           up;
   logic [9:0]           lo;
   logic [1:0]           led;
   logic [2:0]           run;
   int                   errors = 0;
   int                   n_tests = 0;
   int                   cyc = 0;

   hbp_host_model u_hbp_host_model (.link_clk(link_clk),
      .cfg_write(cfg_write), .cfg(cfg));

   hbp_top #(.PERIOD_80_CYC(20'h003e8), .PERIOD_100_CYC(20'h00320),
      .PERIOD_200_CYC(20'h00190)) u_hbp_top (
      .mclk(mclk), .rst(rst), .en_pin(en_pin),
      .load_supply_fault(load_supply_fault), .link_clk(link_clk),
      .cfg_write(cfg_write), .cfg_act_upper(cfg.act_upper),
      .cfg_act_lower(cfg.act_lower), .cfg_assign(cfg.assign_sel),
      .cfg_duty(cfg.duty), .cfg_rate(cfg.rate),
      .cfg_active_fw(cfg.active_fw), .cfg_led_mode_out1(cfg.led_mode[0]),
      .cfg_led_mode_out2(cfg.led_mode[1]),
      .cfg_powerup_ack(cfg.powerup_ack), .powerup_seen_flag_low(flag),
      .upper_gate(up), .lower_gate(lo), .charge_pump_on(pump),
      .sleep_mode(slp), .led_openload_sel(led), .pwm_running(run));

   initial
   begin
      mclk = 1'b0;
      forever #12.5 mclk = ~mclk;
   end

   initial
   begin
      link_clk = 1'b0;
      #7;
      forever #80 link_clk = ~link_clk;
   end

   task automatic give_verdict();
      $display("Checks %0d, mismatches %0d", n_tests, errors);
      if (errors == 0 && n_tests > 0)
         $display("Result: passed");
      else
         $display("Result: failed");
      $finish;
   endtask

   always @(posedge mclk)
   begin
      cyc++;
      if (cyc == 60000)
      begin
         errors++;
         $display("ERROR timeout expected finish seen hang");
         give_verdict();
      end
   end

   task automatic check(input string what, input logic [31:0] exp, got);
      n_tests++;
      if (got !== exp)
      begin
         errors++;
         $display("ERROR %s expected %h seen %h", what, exp, got);
      end
   endtask

   task automatic settle(input int n);
      repeat (n) @(negedge mclk);
   endtask

   task automatic put(input hbp_pkg::hbp_cfg_type w);
      u_hbp_host_model.send(w);
      settle(100);
   endtask

   // High time, period and lower-on count of one upper pulse
   task automatic pulse(input int b, output int hi, per, lh);
      hi = 0;
      lh = 0;
      per = 0;
      // Skip a pulse already under way
      while (up[b] === 1'b1 && per < 4000)
      begin
         settle(1);
         per++;
      end
      while (up[b] !== 1'b1 && per < 4000)
      begin
         settle(1);
         per++;
      end
      per = 0;
      while (up[b] === 1'b1 && hi < 4000)
      begin
         settle(1);
         hi++;
      end
      per = hi;
      while (up[b] !== 1'b1 && per < 4000)
      begin
         lh += (lo[b] === 1'b1);
         settle(1);
         per++;
      end
   endtask

   initial
   begin
      int hi, per, lh;
      rst = 1'b1;
      en_pin = 1'b1;
      load_supply_fault = 1'b0;
      settle(20);
      check("gates in reset", 20'h0, {up, lo});
      check("flag in reset", 1'b0, flag);
      rst = 1'b0;
      settle(20);
      check("pump", 1'b1, pump);
      check("flag after reset", 1'b0, flag);
      $display("reset test done");

      foreach (ROWS[i])
      begin
         c = hbp_pkg::CFG_RESET;
         c.act_upper = ROWS[i].up;
         c.act_lower = ROWS[i].lo;
         c.assign_sel = ROWS[i].asg;
         c.active_fw = ROWS[i].fw;
         c.led_mode = ROWS[i].led;
         put(c);
         check("upper", ROWS[i].eu, up);
         check("lower", ROWS[i].el, lo);
         check("led sel", ROWS[i].led, led);
      end
      $display("table test done");

      for (int k = 1; k < 4; k++)
      begin
         c = hbp_pkg::CFG_RESET;
         c.assign_sel[1:0] = 2'(k);
         c.duty[8*(k-1) +: 8] = 8'h40;
         put(c);
         if (k == 3)
         begin
            // Activation and LED select before the rate
            c.act_upper = 10'h001;
            c.led_mode = 2'h1;
            put(c);
            check("led sel", 2'h1, led);
         end
         c.rate[2*(k-1) +: 2] = 2'(k);
         put(c);
         c.act_upper = 10'h001;
         put(c);
         pulse(0, hi, per, lh);
         pulse(0, hi, per, lh);
         check("high time", PER[k] / 4, hi);
         check("period", PER[k], per);
         check("running", 3'h1 << (k - 1), run);
         check("passive lower", 0, lh);
      end
      $display("rate test done");

      c.duty[16 +: 8] = 8'hc0;
      u_hbp_host_model.send(c);
      for (int k = 0; k < 3; k++)
      begin
         pulse(0, hi, per, lh);
         check("glitch free", 1, hi == 100 || hi == 300);
      end
      check("new duty", 300, hi);
      $display("update test done");

      c.active_fw = 1'b1;
      c.duty[16 +: 8] = 8'h80;
      put(c);
      pulse(0, hi, per, lh);
      pulse(0, hi, per, lh);
      check("active lower", 1, lh > 0);
      c.duty[16 +: 8] = 8'h02;
      put(c);
      pulse(0, hi, per, lh);
      pulse(0, hi, per, lh);
      check("short on-time", 0, lh);
      c.rate = 6'h00;
      put(c);
      check("stopped", 3'h0, run);
      check("swap", 20'h00001, {up, lo});
      $display("freewheel test done");

      load_supply_fault = 1'b1;
      settle(10);
      check("fault gates", 20'h0, {up, lo});
      load_supply_fault = 1'b0;
      settle(100);
      check("recovered", 20'h00001, {up, lo});
      $display("load supply test done");

      c.powerup_ack = 1'b1;
      c.led_mode = 2'h3;
      put(c);
      check("flag set", 1'b1, flag);
      en_pin = 1'b0;
      settle(100);
      check("sleep", 3'h4, {slp, pump, flag});
      check("sleep gates", 22'h0, {led, up, lo});
      en_pin = 1'b1;
      settle(100);
      check("wake", 3'h2, {slp, pump, flag});
      check("wake gates", 22'h0, {led, up, lo});
      put(c);
      rst = 1'b1;
      settle(5);
      check("mid reset", 21'h0, {flag, up, lo});
      rst = 1'b0;
      settle(20);
      check("pump after reset", 1'b1, pump);
      check("config after reset", 21'h0, {flag, up, lo});
      $display("sleep and reset test done");
      give_verdict();
   end
endmodule
